// *** hdl/clpm_top.sv ***
// csi-2 lane power state, clock lane mode and control bus slave
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module clpm_top #(
   parameter int unsigned WAKE_CYCLES = clpm_pkg::WAKE_CYC
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic [1:0] slave_addr_select_pins,
   input wire logic lane_clk,
   input wire logic hsync_i,
   input wire logic vsync_i,
   input wire logic de_i,
   output clpm_pkg::clpm_lanes_t lanes
);
   // ************************************************************
   // core domain declarations
   // ************************************************************
   logic [1:0] ctrl_q;
   logic s_axi_awready_q;
   logic s_axi_wready_q;
   logic s_axi_bvalid_q;
   logic [1:0] s_axi_bresp_q;
   logic s_axi_arready_q;
   logic s_axi_rvalid_q;
   logic [31:0] s_axi_rdata_q;
   logic [1:0] s_axi_rresp_q;
   logic [3:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_fire;
   logic scl_s1, scl_s2, scl_s3;
   logic sda_s1, sda_s2, sda_s3;
   logic [1:0] pin_s1, pin_s2;
   logic [1:0] pin_q;
   logic strap_done_q;
   logic i2c_act_q;
   logic [3:0] i2c_cnt_q;
   logic i2c_ackph_q;
   logic [1:0] i2c_byte_q;
   logic [7:0] i2c_sh_q;
   logic [7:0] i2c_idx_q;
   logic i2c_wr_q;
   logic [7:0] i2c_wdata_q;
   logic sda_oe_q;
   logic sda_o_q;
   logic i2c_ok;
   logic scl_rise, scl_fall, i2c_start, i2c_stop;
   logic req_s1, req_s2;
   logic ack_q;
   clpm_pkg::clpm_stat_t stat_core_q;
   // ************************************************************
   // link domain declarations
   // ************************************************************
   logic rst_l1, rst_l2;
   logic stby_s1, stby_s2;
   logic cont_s1, cont_s2;
   logic ack_s1, ack_s2;
   logic req_q;
   clpm_pkg::clpm_stat_t stat_link_q;
   clpm_pkg::clpm_link_st_t st_q;
   clpm_pkg::clpm_lanes_t lanes_q;
   logic [15:0] cnt_q;
   logic hs_d, vs_d, de_d;
   logic [11:0] pix_cnt_q, line_cnt_q, hb_cnt_q;
   logic [11:0] htot_q, vtot_q, hb_len_q;
   logic hb_long, data_hs, clk_run;
   logic lut_hit_q, hi_q;
   logic [1:0] lut_idx_q;
   logic lut_hit_c, hi_c;
   logic [1:0] lut_idx_c;

   assign s_axi_awready = s_axi_awready_q;
   assign s_axi_wready = s_axi_wready_q;
   assign s_axi_bvalid = s_axi_bvalid_q;
   assign s_axi_bresp = s_axi_bresp_q;
   assign s_axi_arready = s_axi_arready_q;
   assign s_axi_rvalid = s_axi_rvalid_q;
   assign s_axi_rdata = s_axi_rdata_q;
   assign s_axi_rresp = s_axi_rresp_q;
   assign sda_o = sda_o_q;
   assign sda_oe = sda_oe_q;
   assign lanes = lanes_q;

   // ************************************************************
   // axi4-lite slave
   // ************************************************************
   assign wr_fire = ~s_axi_awready_q & ~s_axi_wready_q & ~s_axi_bvalid_q;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_axi_awready_q <= 1'b1;
         awaddr_q <= 4'h0;
      end else if (s_axi_awvalid && s_axi_awready_q) begin
         s_axi_awready_q <= 1'b0;
         awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         s_axi_awready_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_axi_wready_q <= 1'b1;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready_q) begin
         s_axi_wready_q <= 1'b0;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         s_axi_wready_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_axi_bvalid_q <= 1'b0;
         s_axi_bresp_q <= clpm_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid_q <= 1'b1;
         if (awaddr_q == clpm_pkg::REG_CTRL) begin
            s_axi_bresp_q <= clpm_pkg::RESP_OKAY;
         end else begin
            s_axi_bresp_q <= clpm_pkg::RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_axi_arready_q <= 1'b1;
         s_axi_rvalid_q <= 1'b0;
         s_axi_rdata_q <= 32'h0000_0000;
         s_axi_rresp_q <= clpm_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready_q) begin
         s_axi_arready_q <= 1'b0;
         s_axi_rvalid_q <= 1'b1;
         s_axi_rresp_q <= clpm_pkg::RESP_OKAY;
         case (s_axi_araddr)
            clpm_pkg::REG_CTRL: begin
               s_axi_rdata_q <= {30'h0000_0000, ctrl_q};
            end
            clpm_pkg::REG_STATUS: begin
               s_axi_rdata_q <= {12'h000, stat_core_q.horizontal_blank_pixels, 1'b0,
                  stat_core_q.lut_idx, stat_core_q.lut_hit, stat_core_q.hb_long,
                  stat_core_q.hi_rate, stat_core_q.clk_hs, stat_core_q.ulps};
            end
            clpm_pkg::REG_TIMING: begin
               s_axi_rdata_q <= {4'h0, stat_core_q.total_lines_per_frame, 4'h0,
                  stat_core_q.total_pixels_per_line};
            end
            default: begin
               s_axi_rdata_q <= 32'h0000_0000;
               s_axi_rresp_q <= clpm_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid_q && s_axi_rready) begin
         s_axi_rvalid_q <= 1'b0;
         s_axi_arready_q <= 1'b1;
      end
   end

   // control bits: the control bus write lands after a same-cycle bus write
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl_q <= clpm_pkg::CTRL_RST;
      end else begin
         if (wr_fire && awaddr_q == clpm_pkg::REG_CTRL && wstrb_q[0]) begin
            ctrl_q <= wdata_q[1:0];
         end
         if (i2c_wr_q && i2c_idx_q == clpm_pkg::I2C_IDX_CTRL) begin
            ctrl_q <= i2c_wdata_q[1:0];
         end
      end
   end

   // ************************************************************
   // control bus slave
   // ************************************************************
   always_ff @(posedge core_clk) begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      pin_s1 <= slave_addr_select_pins;
      pin_s2 <= pin_s1;
   end

   // address pins caught once, on the first edge after reset release
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         strap_done_q <= 1'b0;
         pin_q <= 2'h0;
      end else if (!strap_done_q) begin
         strap_done_q <= 1'b1;
         pin_q <= pin_s2;
      end
   end

   assign scl_rise = scl_s2 & ~scl_s3;
   assign scl_fall = ~scl_s2 & scl_s3;
   assign i2c_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   assign i2c_stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
   // address byte must match the strapped address with write bit; reads are refused
   assign i2c_ok = (i2c_byte_q != 2'h0) ||
      (i2c_sh_q[7:1] == clpm_pkg::I2C_ADDR[pin_q] && !i2c_sh_q[0]);

   always_ff @(posedge core_clk) begin
      i2c_wr_q <= 1'b0;
      sda_o_q <= 1'b0;
      if (sys_rst || i2c_stop) begin
         i2c_act_q <= 1'b0;
         i2c_cnt_q <= 4'h0;
         i2c_ackph_q <= 1'b0;
         i2c_byte_q <= 2'h0;
         sda_oe_q <= 1'b0;
         if (sys_rst) begin
            i2c_sh_q <= 8'h00;
            i2c_idx_q <= 8'h00;
            i2c_wdata_q <= 8'h00;
         end
      end else if (i2c_start) begin
         i2c_act_q <= 1'b1;
         i2c_cnt_q <= 4'h0;
         i2c_ackph_q <= 1'b0;
         i2c_byte_q <= 2'h0;
         sda_oe_q <= 1'b0;
      end else if (i2c_act_q) begin
         if (scl_rise && i2c_cnt_q != 4'h8) begin
            i2c_sh_q <= {i2c_sh_q[6:0], sda_s2};
            i2c_cnt_q <= i2c_cnt_q + 4'h1;
         end else if (scl_fall && i2c_cnt_q == 4'h8) begin
            if (!i2c_ackph_q) begin
               i2c_ackph_q <= 1'b1;
               sda_oe_q <= i2c_ok;
               i2c_act_q <= i2c_ok;
               if (i2c_byte_q == 2'h1) begin
                  i2c_idx_q <= i2c_sh_q;
               end
               if (i2c_byte_q == 2'h2) begin
                  i2c_wr_q <= 1'b1;
                  i2c_wdata_q <= i2c_sh_q;
               end
            end else begin
               i2c_ackph_q <= 1'b0;
               i2c_cnt_q <= 4'h0;
               sda_oe_q <= 1'b0;
               if (i2c_byte_q == 2'h2) begin
                  i2c_idx_q <= i2c_idx_q + 8'h01;
               end else begin
                  i2c_byte_q <= i2c_byte_q + 2'h1;
               end
            end
         end
      end
   end

   // ************************************************************
   // status crossing, core side
   // ************************************************************
   always_ff @(posedge core_clk) begin
      req_s1 <= req_q;
      req_s2 <= req_s1;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ack_q <= 1'b0;
         stat_core_q <= '0;
      end else if (req_s2 != ack_q) begin
         ack_q <= req_s2;
         stat_core_q <= stat_link_q;
      end
   end

   // ************************************************************
   // link domain: reset, control and status crossing
   // ************************************************************
   always_ff @(posedge lane_clk) begin
      rst_l1 <= sys_rst;
      rst_l2 <= rst_l1;
      stby_s1 <= ctrl_q[clpm_pkg::CTRL_STBY_BIT];
      stby_s2 <= stby_s1;
      cont_s1 <= ctrl_q[clpm_pkg::CTRL_CONT_BIT];
      cont_s2 <= cont_s1;
      ack_s1 <= ack_q;
      ack_s2 <= ack_s1;
   end

   // snapshot is held stable until the core side has acknowledged it
   always_ff @(posedge lane_clk) begin
      if (rst_l2) begin
         req_q <= 1'b0;
         stat_link_q <= '0;
      end else if (ack_s2 == req_q) begin
         req_q <= ~req_q;
         stat_link_q.ulps <= (st_q == clpm_pkg::LK_ULPS);
         stat_link_q.clk_hs <= (lanes_q.clk == clpm_pkg::LN_HS);
         stat_link_q.hi_rate <= hi_q;
         stat_link_q.hb_long <= hb_long;
         stat_link_q.lut_hit <= lut_hit_q;
         stat_link_q.lut_idx <= lut_idx_q;
         stat_link_q.horizontal_blank_pixels <= hb_len_q;
         stat_link_q.total_pixels_per_line <= htot_q;
         stat_link_q.total_lines_per_frame <= vtot_q;
      end
   end

   // ************************************************************
   // link domain: line and blank measurement
   // ************************************************************
   always_ff @(posedge lane_clk) begin
      if (rst_l2) begin
         hs_d <= 1'b0;
         vs_d <= 1'b0;
         de_d <= 1'b0;
         pix_cnt_q <= 12'h000;
         line_cnt_q <= 12'h000;
         htot_q <= 12'h000;
         vtot_q <= 12'h000;
      end else begin
         hs_d <= hsync_i;
         vs_d <= vsync_i;
         de_d <= de_i;
         if (hsync_i && !hs_d) begin
            pix_cnt_q <= 12'h000;
            htot_q <= pix_cnt_q + 12'h001;
            line_cnt_q <= line_cnt_q + 12'h001;
         end else if (pix_cnt_q != 12'hFFF) begin
            pix_cnt_q <= pix_cnt_q + 12'h001;
         end
         if (vsync_i && !vs_d) begin
            vtot_q <= line_cnt_q;
            line_cnt_q <= 12'h000;
         end
      end
   end

   // blank length is the run of inactive pixels ending at the next active pixel
   always_ff @(posedge lane_clk) begin
      if (rst_l2) begin
         hb_cnt_q <= 12'h000;
         hb_len_q <= 12'h000;
      end else if (de_i) begin
         hb_cnt_q <= 12'h000;
         if (!de_d && vsync_i) begin
            hb_len_q <= hb_cnt_q;
         end
      end else if (hb_cnt_q != 12'hFFF) begin
         hb_cnt_q <= hb_cnt_q + 12'h001;
      end
   end

   assign hb_long = hb_len_q > clpm_pkg::HB_THRESH;

   // ************************************************************
   // link domain: timing lookup
   // ************************************************************
   always_comb begin
      lut_hit_c = 1'b0;
      lut_idx_c = 2'h0;
      hi_c = 1'b0;
      for (int i = 0; i < clpm_pkg::LUT_N; i++) begin
         if (htot_q == clpm_pkg::LUT_HTOT[i] && vtot_q == clpm_pkg::LUT_VTOT[i]) begin
            lut_hit_c = 1'b1;
            lut_idx_c = 2'(i);
            hi_c = clpm_pkg::LUT_HI[i];
         end
      end
   end

   // an unknown timing counts as low rate, which keeps the clock lane running while vsync_i is high
   always_ff @(posedge lane_clk) begin
      if (rst_l2) begin
         lut_hit_q <= 1'b0;
         lut_idx_q <= 2'h0;
         hi_q <= 1'b0;
      end else begin
         lut_hit_q <= lut_hit_c;
         lut_idx_q <= lut_idx_c;
         hi_q <= hi_c;
      end
   end

   // ************************************************************
   // link domain: lane state machine
   // ************************************************************
   assign data_hs = de_i & vsync_i;
   assign clk_run = cont_s2 | (vsync_i & (~hi_q | de_i | ~hb_long));

   always_ff @(posedge lane_clk) begin
      if (rst_l2) begin
         st_q <= clpm_pkg::LK_RUN;
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
         case (st_q)
            clpm_pkg::LK_RUN: begin
               if (stby_s2 && !data_hs) begin
                  st_q <= clpm_pkg::LK_STOP;
               end
            end
            clpm_pkg::LK_STOP: begin
               cnt_q <= 16'h0000;
               if (stby_s2) begin
                  st_q <= clpm_pkg::LK_ESC;
               end else begin
                  st_q <= clpm_pkg::LK_RUN;
               end
            end
            clpm_pkg::LK_ESC: begin
               if (cnt_q == 16'(clpm_pkg::ESC_CYC - 1)) begin
                  st_q <= clpm_pkg::LK_ULCMD;
                  cnt_q <= 16'h0000;
               end
            end
            clpm_pkg::LK_ULCMD: begin
               if (cnt_q == 16'(clpm_pkg::ULCMD_CYC - 1)) begin
                  st_q <= clpm_pkg::LK_ULPS;
               end
            end
            clpm_pkg::LK_ULPS: begin
               cnt_q <= 16'h0000;
               if (!stby_s2) begin
                  st_q <= clpm_pkg::LK_WAKE;
               end
            end
            clpm_pkg::LK_WAKE: begin
               if (cnt_q == 16'(WAKE_CYCLES - 1)) begin
                  st_q <= clpm_pkg::LK_STOP;
               end
            end
            default: begin
               st_q <= clpm_pkg::LK_RUN;
            end
         endcase
      end
   end

   // every lane follows the same low-power sequence
   always_ff @(posedge lane_clk) begin
      if (rst_l2) begin
         lanes_q <= {clpm_pkg::LN_STOP, clpm_pkg::LN_STOP, clpm_pkg::LN_STOP};
      end else begin
         case (st_q)
            clpm_pkg::LK_RUN: begin
               lanes_q.clk <= clk_run ? clpm_pkg::LN_HS : clpm_pkg::LN_STOP;
               lanes_q.d0 <= data_hs ? clpm_pkg::LN_HS : clpm_pkg::LN_STOP;
               lanes_q.d1 <= data_hs ? clpm_pkg::LN_HS : clpm_pkg::LN_STOP;
            end
            clpm_pkg::LK_ESC: begin
               lanes_q <= {clpm_pkg::LN_ESC, clpm_pkg::LN_ESC, clpm_pkg::LN_ESC};
            end
            clpm_pkg::LK_ULCMD: begin
               lanes_q <= {clpm_pkg::LN_ULCMD, clpm_pkg::LN_ULCMD, clpm_pkg::LN_ULCMD};
            end
            clpm_pkg::LK_ULPS: begin
               lanes_q <= {clpm_pkg::LN_ULPS, clpm_pkg::LN_ULPS, clpm_pkg::LN_ULPS};
            end
            clpm_pkg::LK_WAKE: begin
               lanes_q <= {clpm_pkg::LN_MARK1, clpm_pkg::LN_MARK1, clpm_pkg::LN_MARK1};
            end
            default: begin
               lanes_q <= {clpm_pkg::LN_STOP, clpm_pkg::LN_STOP, clpm_pkg::LN_STOP};
            end
         endcase
      end
   end
endmodule : clpm_top

// *** pkg/clpm_pkg.sv ***
// shared constants and types of the csi-2 lane power and clock mode block
package clpm_pkg;
   // ************************************************************
   // register map (axi4-lite byte addresses)
   // ************************************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_TIMING = 4'h8;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam int unsigned CTRL_STBY_BIT = 0;
   localparam int unsigned CTRL_CONT_BIT = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ************************************************************
   // control bus slave
   // ************************************************************
   localparam logic [7:0] I2C_IDX_CTRL = 8'h10;
   localparam logic [3:0][6:0] I2C_ADDR = {7'h37, 7'h36, 7'h3D, 7'h3C};
   // ************************************************************
   // timing
   // ************************************************************
   localparam logic [11:0] HB_THRESH = 12'h046;
   localparam int unsigned WAKEUP_NS = 1000000;
   localparam int unsigned LINK_PERIOD_NS = 30;
   localparam int unsigned WAKE_CYC = (WAKEUP_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
   localparam int unsigned ESC_CYC = 4;
   localparam int unsigned ULCMD_CYC = 8;
   // ************************************************************
   // timing lookup: total pixels, total lines, high pixel rate flag
   // ************************************************************
   localparam int unsigned LUT_N = 4;
   localparam logic [3:0][11:0] LUT_HTOT = {12'h6C0, 12'h320, 12'h540, 12'h3C0};
   localparam logic [3:0][11:0] LUT_VTOT = {12'h252, 12'h20D, 12'h326, 12'h210};
   localparam logic [3:0] LUT_HI = 4'hA;
   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [5:0] {
      LK_RUN = 6'b00_0001,
      LK_STOP = 6'b00_0010,
      LK_ESC = 6'b00_0100,
      LK_ULCMD = 6'b00_1000,
      LK_ULPS = 6'b01_0000,
      LK_WAKE = 6'b10_0000
   } clpm_link_st_t;
   typedef enum logic [2:0] {
      LN_STOP = 3'h0,
      LN_HS = 3'h1,
      LN_ESC = 3'h2,
      LN_ULCMD = 3'h3,
      LN_ULPS = 3'h4,
      LN_MARK1 = 3'h5
   } clpm_lane_t;
   typedef struct packed {
      clpm_lane_t clk;
      clpm_lane_t d0;
      clpm_lane_t d1;
   } clpm_lanes_t;
   typedef struct packed {
      logic ulps;
      logic clk_hs;
      logic hi_rate;
      logic hb_long;
      logic lut_hit;
      logic [1:0] lut_idx;
      logic [11:0] horizontal_blank_pixels;
      logic [11:0] total_pixels_per_line;
      logic [11:0] total_lines_per_frame;
   } clpm_stat_t;
endpackage : clpm_pkg

// *** verification/clpm_rx_model.sv ***
// receiver model: flags ulps on all lanes reached through escape entry
`timescale 1ns/1ns
module clpm_rx_model (
   input logic lane_clk,
   input clpm_pkg::clpm_lanes_t lanes,
   output logic ulps_ok_q
);
   logic esc_q = 1'b0;
   initial ulps_ok_q = 1'b0;
   always @(posedge lane_clk) begin
      esc_q <= esc_q | (lanes.d0 == clpm_pkg::LN_ESC);
      ulps_ok_q <= ulps_ok_q | (esc_q && lanes == {3{clpm_pkg::LN_ULPS}});
   end
endmodule : clpm_rx_model

// *** verification/clpm_top_monitor.sv ***
// assertions on lane states and the control bus data line
`timescale 1ns/1ns
module clpm_top_monitor #(
   parameter int unsigned WAKE_CYCLES = 20
) (
   input logic core_clk,
   input logic sys_rst,
   input logic sda_o,
   input logic lane_clk,
   input clpm_pkg::clpm_lanes_t lanes
);
   logic [15:0] mk_q;
   // length of the current mark-1 run
   always_ff @(posedge lane_clk) begin
      if (sys_rst || lanes.d0 != clpm_pkg::LN_MARK1) begin
         mk_q <= 16'h0000;
      end else begin
         mk_q <= mk_q + 16'h0001;
      end
   end
   sequence enter_s(clpm_pkg::clpm_lane_t st);
      lanes.d0 != st ##1 lanes.d0 == st;
   endsequence
   sequence leave_s(clpm_pkg::clpm_lane_t st);
      lanes.d0 == st ##1 lanes.d0 != st;
   endsequence
   sda_low_a: assert property (@(posedge core_clk) disable iff (sys_rst) sda_o == 1'b0)
      else $error("data line driven high");
   all_ulps_a: assert property (@(posedge lane_clk) disable iff (sys_rst)
      lanes.d0 == clpm_pkg::LN_ULPS |-> lanes == {3{clpm_pkg::LN_ULPS}})
      else $error("lanes not all in ulps");
   esc_cmd_a: assert property (@(posedge lane_clk) disable iff (sys_rst)
      enter_s(clpm_pkg::LN_ULCMD) |-> $past(lanes.d0) == clpm_pkg::LN_ESC)
      else $error("ulps command without escape");
   from_stop_a: assert property (@(posedge lane_clk) disable iff (sys_rst)
      enter_s(clpm_pkg::LN_ESC) |-> $past(lanes.d0) == clpm_pkg::LN_STOP)
      else $error("escape not from stop");
   ulps_hold_a: assert property (@(posedge lane_clk) disable iff (sys_rst)
      lanes.d0 == clpm_pkg::LN_ULPS |=> lanes.d0 inside {clpm_pkg::LN_ULPS, clpm_pkg::LN_MARK1})
      else $error("ulps left wrongly");
   ulps_exit_a: assert property (@(posedge lane_clk) disable iff (sys_rst)
      leave_s(clpm_pkg::LN_ULPS) |-> lanes.d0 == clpm_pkg::LN_MARK1)
      else $error("ulps exit without mark-1");
   wake_stop_a: assert property (@(posedge lane_clk) disable iff (sys_rst)
      leave_s(clpm_pkg::LN_MARK1) |-> lanes.d0 == clpm_pkg::LN_STOP)
      else $error("mark-1 not followed by stop");
   wake_len_a: assert property (@(posedge lane_clk) disable iff (sys_rst)
      leave_s(clpm_pkg::LN_MARK1) |-> mk_q == WAKE_CYCLES)
      else $error("mark-1 length wrong");
endmodule : clpm_top_monitor
bind clpm_top clpm_top_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) clpm_top_monitor_inst (
   .core_clk(core_clk), .sys_rst(sys_rst), .sda_o(sda_o), .lane_clk(lane_clk), .lanes(lanes));

// *** verification/clpm_top_test.sv ***
// bench for the lane power and clock mode block
`timescale 1ns/1ns
module clpm_top_test;
   logic core_clk = 1'b0;
   logic lane_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] awaddr = 4'h0;
   logic [3:0] araddr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic scl = 1'b1, sda_m = 1'b1, hs = 1'b0, vs = 1'b0, de = 1'b0;
   logic [1:0] pins = 2'h2;
   logic awready, wready, bvalid, arready, rvalid, sda_o, sda_oe, rx_ok;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   clpm_pkg::clpm_lanes_t lanes;
   // open-drain wire with pull-up
   wire sda = sda_m & (sda_oe ? sda_o : 1'b1);
   int error_cnt = 0;
   int comparisons = 0;
   initial forever #2 core_clk = ~core_clk;
   initial #7 forever #15 lane_clk = ~lane_clk;
   clpm_top #(.WAKE_CYCLES(20)) clpm_top_inst (
      .core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .slave_addr_select_pins(pins),
      .lane_clk(lane_clk), .hsync_i(hs), .vsync_i(vs), .de_i(de), .lanes(lanes));
   clpm_rx_model clpm_rx_model_inst (.lane_clk(lane_clk), .lanes(lanes), .ulps_ok_q(rx_ok));
   task automatic test_done;
      $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic guard(input int n);
      if (n >= 3000) begin
         chk(32'h0000_0000, 32'h0000_0001);
         test_done();
      end
   endtask : guard
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
      int n;
      n = 0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         awvalid <= awvalid & (awready !== 1'b1);
         wvalid <= wvalid & (wready !== 1'b1);
      end while (bvalid !== 1'b1 && n < 3000);
      guard(n);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [3:0] a);
      int n;
      n = 0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         arvalid <= arvalid & (arready !== 1'b1);
      end while (rvalid !== 1'b1 && n < 3000);
      guard(n);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_rd
   task automatic i2c_bit(input logic b);
      scl <= 1'b0;
      tick(5);
      sda_m <= b;
      tick(5);
      scl <= 1'b1;
      tick(10);
   endtask : i2c_bit
   // one byte msb first, then the acknowledge slot; sda low there means ack
   task automatic i2c_byte(input logic [7:0] v, input logic ack);
      for (int i = 7; i >= 0; i--) begin
         i2c_bit(v[i]);
      end
      i2c_bit(1'b1);
      chk({31'h0, sda}, {31'h0, ~ack});
   endtask : i2c_byte
   // start, address, index 0x10 and standby data only when ack is expected, stop
   task automatic i2c_wr(input logic [6:0] a, input logic ack);
      sda_m <= 1'b0;
      tick(10);
      i2c_byte({a, 1'b0}, ack);
      if (ack) begin
         i2c_byte(clpm_pkg::I2C_IDX_CTRL, 1'b1);
         i2c_byte(8'h01, 1'b1);
      end
      i2c_bit(1'b0);
      sda_m <= 1'b1;
      tick(10);
   endtask : i2c_wr
   task automatic wait_d0(input clpm_pkg::clpm_lane_t st);
      int n;
      n = 0;
      while (lanes.d0 !== st && n < 3000) begin
         tick(1);
         n++;
      end
      guard(n);
   endtask : wait_d0
   task automatic line(input int hb);
      for (int i = 0; i < 1344; i++) begin
         @(posedge lane_clk);
         vs <= 1'b1;
         hs <= (i == 0);
         de <= (i >= hb);
      end
   endtask : line
   initial begin
      tick(12);
      sys_rst <= 1'b0;
      axi_rd(clpm_pkg::REG_CTRL);
      chk(d, 32'h0000_0000);
      axi_rd(4'hC);
      chk({30'h0, r}, {30'h0, clpm_pkg::RESP_SLVERR});
      $display("register test done");
      axi_wr(clpm_pkg::REG_CTRL, 32'h0000_0002);
      chk({30'h0, r}, 32'h0000_0000);
      tick(60);
      chk({29'h0, lanes.clk}, {29'h0, clpm_pkg::LN_HS});
      axi_wr(clpm_pkg::REG_CTRL, 32'h0000_0000);
      tick(60);
      chk({29'h0, lanes.clk}, {29'h0, clpm_pkg::LN_STOP});
      $display("clock mode test done");
      i2c_wr(7'h3C, 1'b0);
      i2c_wr(7'h36, 1'b1);
      wait_d0(clpm_pkg::LN_ULPS);
      chk({23'h0, lanes}, {23'h0, {3{clpm_pkg::LN_ULPS}}});
      tick(10);
      chk({31'h0, rx_ok}, 32'h0000_0001);
      axi_rd(clpm_pkg::REG_CTRL);
      chk(d, 32'h0000_0001);
      axi_wr(clpm_pkg::REG_CTRL, 32'h0000_0000);
      wait_d0(clpm_pkg::LN_MARK1);
      wait_d0(clpm_pkg::LN_STOP);
      tick(20);
      chk({23'h0, lanes}, 32'h0000_0000);
      $display("standby test done");
      repeat (2) line(70);
      tick(100);
      axi_rd(clpm_pkg::REG_STATUS);
      chk(d & 32'h000F_FF08, 32'h0000_4600);
      repeat (2) line(71);
      tick(100);
      axi_rd(clpm_pkg::REG_STATUS);
      chk(d & 32'h000F_FF08, 32'h0000_4708);
      axi_rd(clpm_pkg::REG_TIMING);
      chk(d & 32'h0000_0FFF, 32'h0000_0540);
      @(posedge lane_clk);
      de <= 1'b0;
      repeat (5) @(posedge lane_clk);
      chk({29'h0, lanes.clk}, {29'h0, clpm_pkg::LN_HS});
      vs <= 1'b0;
      repeat (5) @(posedge lane_clk);
      chk({29'h0, lanes.clk}, {29'h0, clpm_pkg::LN_STOP});
      repeat (1606) @(posedge lane_clk) hs <= ~hs;
      repeat (2) line(71);
      repeat (5) @(posedge lane_clk) de <= 1'b0;
      chk({29'h0, lanes.clk}, {29'h0, clpm_pkg::LN_STOP});
      $display("video test done");
      test_done();
   end
endmodule : clpm_top_test
